// >>> api_framer_pkg.sv
// Constants, field offsets and state types for the API frame command framer.
// Assumes one 100 MHz clock and a byte stream from the host serial side.
// Function
// - Queued-parameter command stores the new value as pending only.
// - Pending values become active on immediate command or apply-changes.
// - A queued-parameter read is answered at once with the active value.
// - Frame is delimiter, two-byte length MSB first, body, checksum.
// - Frame identifier at offset 4 is echoed; zero suppresses the response.
// - Offsets 5 and 6 hold the two-character command name.
// - Value bytes after the name set the parameter; none means query.
// - Checksum is 0xFF minus the low byte of the body sum.
// - One, two or four zero-padded value bytes mean the same value.
// - Transmit request sends its payload as an RF packet to its destination.
// - Coordinator is all-zero plus 0xFFFE, or own address plus 0x0000; the code takes any non-broadcast address plus 0x0000.
// - Transmit status reports the discovered 16-bit network address.
// - Zero broadcast radius means use the maximum-hops setting.
// - Broadcast radius is ignored for unicast transmissions.
// - Allowed payload shrinks two bytes per source-route intermediate hop.
// - Maximum-payload query reports the accepted payload size.
// - Body plus checksum must sum to 0xFF in its low byte.
// - Multi-byte fields travel most significant byte first.
package api_framer_pkg;
    // Frame bytes and frame types
    localparam logic [7:0] DELIM = 8'h7E;
    localparam logic [7:0] TYPE_AT = 8'h08;
    localparam logic [7:0] TYPE_AT_QUEUE = 8'h09;
    localparam logic [7:0] TYPE_TX_REQ = 8'h10;
    localparam logic [7:0] TYPE_AT_RESP = 8'h88;
    localparam logic [7:0] TYPE_TX_STAT = 8'h8B;
    localparam logic [7:0] CSUM_GOOD = 8'hFF;
    // Receive offsets within a frame
    localparam logic [15:0] OFS_LEN_HI = 16'h0001;
    localparam logic [15:0] OFS_TYPE = 16'h0003;
    localparam logic [15:0] OFS_FID = 16'h0004;
    localparam logic [15:0] OFS_CMD0 = 16'h0005;
    localparam logic [15:0] OFS_CMD1 = 16'h0006;
    localparam logic [15:0] OFS_VALUE = 16'h0007;
    localparam logic [15:0] OFS_D64_LAST = 16'h000C;
    localparam logic [15:0] OFS_D16_HI = 16'h000D;
    localparam logic [15:0] OFS_D16_LO = 16'h000E;
    localparam logic [15:0] OFS_RADIUS = 16'h000F;
    localparam logic [15:0] OFS_PAYLOAD = 16'h0011;
    localparam logic [15:0] LEN_TO_LAST = 16'h0002;
    localparam logic [15:0] TX_HDR_LEN = 16'h000E;
    localparam logic [15:0] AT_HDR_LEN = 16'h0004;
    localparam logic [15:0] VLEN_1 = 16'h0001;
    localparam logic [15:0] VLEN_2 = 16'h0002;
    localparam logic [15:0] VLEN_4 = 16'h0004;
    // Addresses
    localparam logic [63:0] BCAST64 = 64'h0000_0000_0000_FFFF;
    localparam logic [63:0] COORD64 = 64'h0000_0000_0000_0000;
    localparam logic [15:0] ADDR16_UNKNOWN = 16'hFFFE;
    localparam logic [15:0] ADDR16_COORD = 16'h0000;
    // Parameters reachable by command name: baud, max hops, api mode
    localparam int NUM_PARAMS = 3;
    localparam logic [1:0] PAR_HOPS = 2'h1;
    localparam logic [NUM_PARAMS-1:0][15:0] PARAM_CMD =
        {16'h4150, 16'h4E48, 16'h4244};
    localparam logic [NUM_PARAMS-1:0][7:0] PARAM_RESET =
        {8'h01, 8'h1E, 8'h03};
    localparam logic [15:0] CMD_APPLY = 16'h4143;
    localparam logic [15:0] CMD_PAYLOAD = 16'h4E50;
    localparam logic [7:0] MAX_PAYLOAD = 8'h54;
    localparam logic [15:0] HOP_COST = 16'h0002;
    // Response status codes
    localparam logic [7:0] ST_OK = 8'h00;
    localparam logic [7:0] ST_BAD_CMD = 8'h02;
    localparam logic [7:0] ST_BAD_PARAM = 8'h03;
    localparam logic [7:0] DLV_OK = 8'h00;
    localparam logic [7:0] DLV_FAIL = 8'h01;
    // Response frame layout
    localparam logic [7:0] RESP_LEN_SET = 8'h05;
    localparam logic [7:0] RESP_LEN_QUERY = 8'h06;
    localparam logic [7:0] RESP_LEN_STAT = 8'h07;
    localparam logic [3:0] TX_SUM_FIRST = 4'h3;
    localparam logic [3:0] TX_CSUM_OFS = 4'h3;
    // APB register map
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ACTIVE = 8'h04;
    localparam logic [7:0] REG_PENDING = 8'h08;
    localparam logic [7:0] REG_ROUTE = 8'h0C;
    localparam logic [7:0] REG_STATS = 8'h10;
    localparam int CTRL_APPLY_BIT = 0;
    // Parser states
    typedef enum logic [2:0] {P_DELIM, P_LEN_HI, P_LEN_LO, P_BODY, P_CSUM}
        parse_t;
endpackage

// >>> api_frame_command_framer.sv
// Frame parser, command executor and response builder for the serial API.
// Assumes host bytes arrive synchronous to clk; radio accepts payload bytes
// as they come and reports delivery with a done pulse.
module api_frame_command_framer
    import api_framer_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // APB register port
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Host byte stream in
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    output logic rx_ready,
    // Host byte stream out
    output logic tx_valid,
    output logic [7:0] tx_data,
    input wire logic tx_ready,
    // Radio transmit side
    output logic rf_byte_valid,
    output logic [7:0] rf_byte,
    output logic rf_commit,
    output logic rf_abort,
    output logic [63:0] rf_dest64,
    output logic [15:0] rf_dest16,
    output logic [7:0] rf_radius,
    output logic rf_broadcast,
    output logic rf_coord,
    input wire logic rf_done,
    input wire logic rf_ok,
    input wire logic [15:0] rf_addr16,
    // Operating configuration
    output logic [NUM_PARAMS-1:0][7:0] active
);
    import api_framer_pkg::*;

    parse_t state;
    logic [15:0] idx, frame_len, pay_cnt, val_cnt, allowed, hop_cost;
    logic [7:0] sum, ftype, fid, value, radius, route_hops;
    logic [15:0] cmd, dest16;
    logic [63:0] dest64;
    logic value_ovf, rx_take, frame_end, csum_ok, good, is_at;
    logic [NUM_PARAMS-1:0][7:0] pending;
    logic par_hit, do_set, do_apply, resp_has_val, apb_apply;
    logic [1:0] par_sel;
    logic [7:0] resp_status, resp_val;
    logic at_pend, at_has_val, st_pend, st_ok, load_at, load_st;
    logic [7:0] at_fid, at_status, at_val, st_fid, tx_sum;
    logic [15:0] at_cmd, st_addr16, good_cnt, bad_cnt;
    logic [9:0][7:0] rbuf;
    logic [3:0] tx_idx, tx_last;
    logic apb_setup, apb_access;

    assign rx_take = rx_valid && rx_ready;
    assign frame_end = rx_take && (state == P_CSUM);
    assign csum_ok = (8'(sum + rx_data) == CSUM_GOOD);
    assign good = frame_end && csum_ok;
    assign is_at = (ftype == TYPE_AT) || (ftype == TYPE_AT_QUEUE);
    assign pay_cnt = frame_len - TX_HDR_LEN;
    assign val_cnt = frame_len - AT_HDR_LEN;
    assign hop_cost = {8'h00, route_hops} * HOP_COST;
    assign allowed = (hop_cost > {8'h00, MAX_PAYLOAD}) ? 16'h0000 :
        {8'h00, MAX_PAYLOAD} - hop_cost;
    // Stall the host while a command answer waits, so no command answer is overwritten
    assign rx_ready = !at_pend;

    // delimiter hunt, length MSB first, then body and checksum
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= P_DELIM;
        end else if (rx_take) begin
            unique case (state)
                P_DELIM: if (rx_data == DELIM) state <= P_LEN_HI;
                P_LEN_HI: state <= P_LEN_LO;
                P_LEN_LO: state <= ({frame_len[15:8], rx_data} == 16'h0000)
                    ? P_DELIM : P_BODY;
                P_BODY: if (idx == frame_len + LEN_TO_LAST) state <= P_CSUM;
                P_CSUM: state <= P_DELIM;
            endcase
        end
    end

    // length and offset tracking, big endian
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            idx <= 16'h0000;
            frame_len <= 16'h0000;
            sum <= 8'h00;
        end else if (rx_take) begin
            idx <= (state == P_DELIM) ? OFS_LEN_HI : idx + 16'h0001;
            if (state == P_LEN_HI) frame_len[15:8] <= rx_data;
            if (state == P_LEN_LO) frame_len[7:0] <= rx_data;
            sum <= (state == P_BODY) ? 8'(sum + rx_data) : 8'h00;
        end
    end

    // Field capture by offset; destination shifts in MSB first
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ftype <= 8'h00;
            fid <= 8'h00;
            cmd <= 16'h0000;
            value <= 8'h00;
            value_ovf <= 1'b0;
            dest64 <= 64'h0000_0000_0000_0000;
            dest16 <= 16'h0000;
            radius <= 8'h00;
        end else if (rx_take && state == P_LEN_LO) begin
            value <= 8'h00;
            value_ovf <= 1'b0;
        end else if (rx_take && state == P_BODY) begin
            if (idx == OFS_TYPE) ftype <= rx_data;
            if (idx == OFS_FID) fid <= rx_data;
            if (idx == OFS_CMD0) cmd[15:8] <= rx_data;
            if (idx == OFS_CMD1) cmd[7:0] <= rx_data;
            // leading zero bytes drop out, last byte is the value
            if (idx >= OFS_VALUE) begin
                value <= rx_data;
                value_ovf <= value_ovf || (value != 8'h00);
            end
            if (idx >= OFS_CMD0 && idx <= OFS_D64_LAST)
                dest64 <= {dest64[55:0], rx_data};
            if (idx == OFS_D16_HI) dest16[15:8] <= rx_data;
            if (idx == OFS_D16_LO) dest16[7:0] <= rx_data;
            if (idx == OFS_RADIUS) radius <= rx_data;
        end
    end

    // Command decode; parameter names come from a table
    always_comb begin
        par_hit = 1'b0;
        par_sel = 2'h0;
        do_set = 1'b0;
        do_apply = 1'b0;
        resp_has_val = 1'b0;
        resp_val = 8'h00;
        resp_status = ST_OK;
        for (int i = 0; i < NUM_PARAMS; i++) begin
            if (cmd == PARAM_CMD[i]) begin
                par_hit = 1'b1;
                par_sel = 2'(i);
            end
        end
        if (cmd == CMD_APPLY && val_cnt == 16'h0000) begin
            do_apply = 1'b1;
        end else if (cmd == CMD_PAYLOAD && val_cnt == 16'h0000) begin
            resp_has_val = 1'b1;
            resp_val = allowed[7:0];
        end else if (par_hit && val_cnt == 16'h0000) begin
            // query returns the active value at once
            resp_has_val = 1'b1;
            resp_val = active[par_sel];
        end else if (par_hit && !value_ovf && (val_cnt == VLEN_1 ||
                val_cnt == VLEN_2 || val_cnt == VLEN_4)) begin
            do_set = 1'b1;
        end else if (par_hit) begin
            resp_status = ST_BAD_PARAM;
        end else begin
            resp_status = ST_BAD_CMD;
        end
        // immediate command also applies what is queued
        if (ftype == TYPE_AT && resp_status == ST_OK) do_apply = 1'b1;
    end

    // One pending/active pair per parameter
    generate
        for (genvar g = 0; g < NUM_PARAMS; g++) begin : g_param
            logic set_here;
            logic apply_now;
            assign set_here = good && is_at && do_set && (par_sel == 2'(g));
            assign apply_now = (good && is_at && do_apply) || apb_apply;
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    pending[g] <= PARAM_RESET[g];
                end else if (set_here) begin
                    pending[g] <= value;
                end
            end
            // active changes only on an apply event
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    active[g] <= PARAM_RESET[g];
                end else if (apply_now) begin
                    active[g] <= set_here ? value : pending[g];
                end
            end
        end
    endgenerate

    // payload streamed to the radio, decision at the checksum
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rf_byte_valid <= 1'b0;
            rf_byte <= 8'h00;
            rf_commit <= 1'b0;
            rf_abort <= 1'b0;
        end else begin
            rf_byte_valid <= rx_take && state == P_BODY &&
                ftype == TYPE_TX_REQ && idx >= OFS_PAYLOAD;
            if (rx_take && state == P_BODY) rf_byte <= rx_data;
            // oversize payload refused like a bad frame
            // bad checksum is aborted and never committed to the radio
            rf_commit <= good && ftype == TYPE_TX_REQ && pay_cnt <= allowed;
            rf_abort <= frame_end && ftype == TYPE_TX_REQ &&
                !(csum_ok && pay_cnt <= allowed);
        end
    end

    // Destination steering, registered with the commit
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rf_dest64 <= 64'h0000_0000_0000_0000;
            rf_dest16 <= 16'h0000;
            rf_radius <= 8'h00;
            rf_broadcast <= 1'b0;
            rf_coord <= 1'b0;
        end else if (good && ftype == TYPE_TX_REQ) begin
            rf_dest64 <= dest64;
            rf_dest16 <= dest16;
            rf_broadcast <= (dest64 == BCAST64);
            rf_coord <= (dest64 == COORD64 && dest16 == ADDR16_UNKNOWN) ||
                (dest64 != BCAST64 && dest16 == ADDR16_COORD);
            if (dest64 != BCAST64) rf_radius <= 8'h00;
            else if (radius == 8'h00) rf_radius <= active[PAR_HOPS];
            else rf_radius <= radius;
        end
    end

    // Command answer pending; a new answer wins over the load clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            at_pend <= 1'b0;
            at_fid <= 8'h00;
            at_cmd <= 16'h0000;
            at_status <= 8'h00;
            at_val <= 8'h00;
            at_has_val <= 1'b0;
        end else if (good && is_at && fid != 8'h00) begin
            at_pend <= 1'b1;
            at_fid <= fid;
            at_cmd <= cmd;
            at_status <= resp_status;
            at_val <= resp_val;
            at_has_val <= resp_has_val;
        end else if (load_at) begin
            at_pend <= 1'b0;
        end
    end

    // Transmit status pending; rf_done wins over the load clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_pend <= 1'b0;
            st_fid <= 8'h00;
            st_ok <= 1'b0;
            st_addr16 <= 16'h0000;
        end else begin
            if (rf_commit) st_fid <= fid;
            if (rf_done) begin
                st_pend <= (st_fid != 8'h00);
                st_ok <= rf_ok;
                st_addr16 <= rf_addr16;
            end else if (load_st) begin
                st_pend <= 1'b0;
            end
        end
    end

    assign load_at = !tx_valid && at_pend;
    assign load_st = !tx_valid && !at_pend && st_pend;

    // Response builder; checksum is formed while the bytes go out
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_valid <= 1'b0;
            tx_data <= 8'h00;
            tx_idx <= 4'h0;
            tx_last <= 4'h0;
            tx_sum <= 8'h00;
            rbuf <= '0;
        end else if (load_at || load_st) begin
            tx_valid <= 1'b1;
            tx_data <= DELIM;
            tx_idx <= 4'h1;
            tx_sum <= 8'h00;
            rbuf[1] <= 8'h00;
            if (load_at) begin
                rbuf[2] <= at_has_val ? RESP_LEN_QUERY : RESP_LEN_SET;
                tx_last <= 4'(at_has_val ? RESP_LEN_QUERY : RESP_LEN_SET)
                    + TX_CSUM_OFS;
                rbuf[3] <= TYPE_AT_RESP;
                rbuf[4] <= at_fid;
                rbuf[5] <= at_cmd[15:8];
                rbuf[6] <= at_cmd[7:0];
                rbuf[7] <= at_status;
                rbuf[8] <= at_val;
            end else begin
                rbuf[2] <= RESP_LEN_STAT;
                tx_last <= 4'(RESP_LEN_STAT) + TX_CSUM_OFS;
                rbuf[3] <= TYPE_TX_STAT;
                rbuf[4] <= st_fid;
                rbuf[5] <= st_addr16[15:8];
                rbuf[6] <= st_addr16[7:0];
                rbuf[7] <= 8'h00;
                rbuf[8] <= st_ok ? DLV_OK : DLV_FAIL;
                rbuf[9] <= 8'h00;
            end
        end else if (tx_valid && tx_ready) begin
            tx_idx <= tx_idx + 4'h1;
            if (tx_idx > tx_last) begin
                tx_valid <= 1'b0;
            end else if (tx_idx == tx_last) begin
                tx_data <= CSUM_GOOD - tx_sum;
            end else begin
                tx_data <= rbuf[tx_idx];
                if (tx_idx >= TX_SUM_FIRST) tx_sum <= 8'(tx_sum + rbuf[tx_idx]);
            end
        end
    end

    // Frame counters for software
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            good_cnt <= 16'h0000;
            bad_cnt <= 16'h0000;
        end else if (frame_end) begin
            if (csum_ok) good_cnt <= good_cnt + 16'h0001;
            else bad_cnt <= bad_cnt + 16'h0001;
        end
    end

    // APB slave: zero wait, read data latched in the setup cycle
    assign apb_setup = psel && !penable;
    assign apb_access = psel && penable;
    assign pready = 1'b1;
    assign apb_apply = apb_access && pwrite && paddr == REG_CTRL &&
        pwdata[CTRL_APPLY_BIT];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            route_hops <= 8'h00;
        end else if (apb_access && pwrite && paddr == REG_ROUTE) begin
            route_hops <= pwdata[7:0];
        end
    end

    // Unmapped addresses answer with an error and zero data
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (apb_setup) begin
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            unique case (paddr)
                REG_CTRL: prdata <= 32'h0000_0000;
                REG_ACTIVE: prdata <= {8'h00, active};
                REG_PENDING: prdata <= {8'h00, pending};
                REG_ROUTE: prdata <= {24'h00_0000, route_hops};
                REG_STATS: prdata <= {good_cnt, bad_cnt};
                default: pslverr <= 1'b1;
            endcase
        end
    end

    // Checks
    // answer queued right after any command frame with a nonzero frame id
    a_query_answered: assert property (@(posedge clk) disable iff (!rst_n)
        good && is_at && fid != 8'h00 |=> at_pend && !rx_ready)
        else $error("query answer not queued");
    a_queue_holds: assert property (@(posedge clk) disable iff (!rst_n)
        good && ftype == TYPE_AT_QUEUE && do_set && !apb_apply
        |=> $stable(active))
        else $error("queued set changed active config");
    a_apply_copies: assert property (@(posedge clk) disable iff (!rst_n)
        apb_apply && !good |=> active == $past(pending))
        else $error("apply did not copy pending");
    a_fid_zero: assert property (@(posedge clk) disable iff (!rst_n)
        good && is_at && fid == 8'h00 |=> !at_pend)
        else $error("answer sent for zero frame id");
    // every response opens with the delimiter
    a_tx_delim: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(tx_valid) |-> tx_data == DELIM)
        else $error("response without delimiter");
    a_bad_discard: assert property (@(posedge clk) disable iff (!rst_n)
        frame_end && !csum_ok |=> !rf_commit && state == P_DELIM)
        else $error("bad checksum frame acted on");
    a_unicast_radius: assert property (@(posedge clk) disable iff (!rst_n)
        rf_commit && !rf_broadcast |-> rf_radius == 8'h00)
        else $error("radius used on unicast");
    a_bcast_radius: assert property (@(posedge clk) disable iff (!rst_n)
        rf_commit && rf_broadcast && radius == 8'h00
        |-> rf_radius == active[PAR_HOPS])
        else $error("zero radius not replaced");
    a_payload_limit: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(rf_commit) |-> $past(pay_cnt) <= $past(allowed))
        else $error("oversize payload committed");
    c_tx_commit: cover property (@(posedge clk) disable iff (!rst_n)
        rf_commit && rf_broadcast);
    c_query_sent: cover property (@(posedge clk) disable iff (!rst_n)
        load_at ##[1:20] !tx_valid);
    c_bad_frame: cover property (@(posedge clk) disable iff (!rst_n)
        frame_end && !csum_ok);
endmodule

// >>> host_model.sv
// Host side model: sends framed API requests and collects answer bytes.
// Assumes the framer takes a byte at an edge where rx_valid meets rx_ready.
module host_model (
    // Serial link to the framer
    input wire logic clk,
    input wire logic rx_ready,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic tx_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] got[$];
    initial begin
        {rx_valid, rx_data, tx_ready} = '0;
    end
    // Ready toggles each cycle so the answer path must cope with stalls
    always @(posedge clk) begin
        tx_ready <= ~tx_ready;
        if (tx_valid && tx_ready)
            got.push_back(tx_data);
    end
    task automatic send(input logic [7:0] body[$], input logic bad);
        logic [7:0] s;
        logic [7:0] f[$];
        s = 8'h00;
        foreach (body[i]) s += body[i];
        f = {8'h7E, 8'h00, 8'(body.size()), body, (8'hFF - s) ^ {7'h0, bad}};
        foreach (f[i]) begin
            rx_valid <= 1'b1;
            rx_data <= f[i];
            @(posedge clk iff rx_ready);
        end
        rx_valid <= 1'b0;
        // Released data must not look like a held byte
        rx_data <= ~rx_data;
        // Idle edge so the next frame never re-drives rx_valid in this step
        @(posedge clk);
    endtask
endmodule

// >>> api_frame_command_framer_tb.sv
// Self-checking bench for the API framer: APB, host frames, radio side.
// Assumes host_model on the serial link; the bench plays the radio.
module api_frame_command_framer_tb import api_framer_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [7:0] a; logic [31:0] d; logic e;} row_t;
    row_t rows[4] = '{'{REG_CTRL, 32'h0, 1'b0}, '{8'h14, 32'h0, 1'b1},
        '{REG_ACTIVE, 32'h0001_1E03, 1'b0}, '{REG_STATS, 32'h0, 1'b0}};
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, e, rf_coord;
    logic rx_valid, rx_ready, tx_valid, tx_ready, rf_byte_valid, rf_commit;
    logic rf_abort, rf_broadcast, rf_done, rf_ok;
    logic [7:0] paddr, rx_data, tx_data, rf_byte, rf_radius;
    logic [31:0] pwdata, prdata, q;
    logic [15:0] rf_dest16, rf_addr16;
    logic [63:0] rf_dest64;
    logic [7:0] fr[$];
    logic [NUM_PARAMS-1:0][7:0] active;
    int fail_count = 0, n_tests = 0, nbytes = 0, ncommit = 0, nabort = 0;
    api_frame_command_framer dut_u (.*);
    host_model h (.*);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Radio pulses counted at the edge that closes their cycle
    always @(posedge clk) begin
        nbytes += rf_byte_valid;
        ncommit += rf_commit;
        nabort += rf_abort;
    end
    task automatic chk(input logic [63:0] s, input logic [63:0] x);
        n_tests++;
        if (s !== x) begin
            fail_count++;
            $display("wrong value t=%0t seen=%h exp=%h", $time, s, x);
        end
    endtask
    // Setup then access; data taken only at the edge pready is seen
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk iff pready);
        {e, q} = {pslverr, prdata};
        {psel, penable} <= 2'b00;
        // Idle edge so the next call never re-drives psel in this step
        @(posedge clk);
    endtask
    // Waits a bounded time for a whole answer frame
    task automatic rsp(input logic [7:0] b[$]);
        logic [7:0] s;
        s = 8'hFF;
        foreach (b[i]) s -= b[i];
        b = {8'h7E, 8'h00, 8'(b.size()), b, s};
        for (int i = 0; i < 300 && h.got.size() < b.size(); i++) @(posedge clk);
        chk(h.got.size(), b.size());
        foreach (b[i]) chk(h.got[i], b[i]);
        h.got.delete();
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (30000) @(posedge clk);
        fail_count++;
        wrap_up();
    end
    initial begin
        {rst_n, psel, penable, pwrite, rf_done, rf_ok} = '0;
        {paddr, pwdata, rf_addr16} = '0;
        repeat (20) @(posedge clk);
        chk({pready, rx_ready, active}, {2'b11, PARAM_RESET});
        rst_n <= 1'b1;
        @(posedge clk);
        foreach (rows[i]) begin
            apb(1'b0, rows[i].a, 32'h0);
            chk({e, q}, {rows[i].e, rows[i].d});
        end
        // Queued set is answered but stays pending until applied
        h.send('{TYPE_AT_QUEUE, 8'h01, 8'h42, 8'h44, 8'h07}, 1'b0);
        rsp('{TYPE_AT_RESP, 8'h01, 8'h42, 8'h44, ST_OK});
        chk(active, PARAM_RESET);
        apb(1'b1, REG_CTRL, 32'h1);
        @(posedge clk);
        chk(active[0], 8'h07);
        h.send('{TYPE_AT_QUEUE, 8'h00, 8'h42, 8'h44, 8'h00, 8'h05}, 1'b0);
        h.send('{TYPE_AT, 8'h00, 8'h41, 8'h43}, 1'b0);
        repeat (30) @(posedge clk);
        chk(h.got.size(), 0);
        chk(active[0], 8'h05);
        // Corrupt frame dropped, the next one still parsed
        h.send('{TYPE_AT_QUEUE, 8'h06, 8'h42, 8'h44}, 1'b1);
        h.send('{TYPE_AT_QUEUE, 8'h03, 8'h4E, 8'h48}, 1'b0);
        rsp('{TYPE_AT_RESP, 8'h03, 8'h4E, 8'h48, ST_OK, 8'h1E});
        apb(1'b0, REG_STATS, 32'h0);
        chk(q, 32'h0004_0001);
        apb(1'b1, REG_ROUTE, 32'h3);
        h.send('{TYPE_AT_QUEUE, 8'h04, 8'h4E, 8'h50}, 1'b0);
        rsp('{TYPE_AT_RESP, 8'h04, 8'h4E, 8'h50, ST_OK, 8'h4E});
        // Unknown name and a nonzero leading value byte are refused
        h.send('{TYPE_AT_QUEUE, 8'h05, 8'h5A, 8'h5A}, 1'b0);
        rsp('{TYPE_AT_RESP, 8'h05, 8'h5A, 8'h5A, ST_BAD_CMD});
        h.send('{TYPE_AT_QUEUE, 8'h06, 8'h42, 8'h44, 8'h01, 8'h07}, 1'b0);
        rsp('{TYPE_AT_RESP, 8'h06, 8'h42, 8'h44, ST_BAD_PARAM});
        // host sends broadcast and unknown-address markers
        h.send('{TYPE_TX_REQ, 8'h09, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
            8'hFF, 8'hFF, 8'hFF, 8'hFE, 8'h00, 8'h00, 8'hAA, 8'h55}, 1'b0);
        repeat (3) @(posedge clk);
        chk({rf_broadcast, rf_radius}, {1'b1, 8'h1E});
        chk(rf_dest64, BCAST64);
        chk({nbytes, ncommit}, {32'd2, 32'd1});
        chk({rf_byte, rf_dest16}, {8'h55, ADDR16_UNKNOWN});
        {rf_ok, rf_done, rf_addr16} <= {2'b11, 16'h1234};
        @(posedge clk);
        rf_done <= 1'b0;
        rsp('{TYPE_TX_STAT, 8'h09, 8'h12, 8'h34, 8'h00, DLV_OK, 8'h00});
        fr = '{TYPE_TX_REQ, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
            8'h00, 8'h00, 8'hFF, 8'hFE, 8'h05, 8'h00, 8'h11};
        h.send(fr, 1'b0);
        repeat (3) @(posedge clk);
        chk({rf_coord, rf_broadcast, rf_radius}, {2'b10, 8'h00});
        // Corrupt transmit request aborts and is never committed
        h.send(fr, 1'b1);
        // Second coordinator form: a non-broadcast 64-bit address with 16-bit zero
        fr[2] = 8'h13;
        fr[10] = 8'h00;
        fr[11] = 8'h00;
        h.send(fr, 1'b0);
        repeat (3) @(posedge clk);
        chk({rf_coord, rf_dest16}, {1'b1, ADDR16_COORD});
        chk({ncommit, nabort}, {32'd3, 32'd1});
        // Reset in mid-run restores the configuration, then parsing resumes
        rst_n <= 1'b0;
        @(posedge clk);
        chk({pready, rx_ready, active}, {2'b11, PARAM_RESET});
        rst_n <= 1'b1;
        @(posedge clk);
        h.send('{TYPE_AT_QUEUE, 8'h07, 8'h42, 8'h44}, 1'b0);
        rsp('{TYPE_AT_RESP, 8'h07, 8'h42, 8'h44, ST_OK, 8'h03});
        wrap_up();
    end
endmodule
